// ---- fwea_pkg.sv ----
/*
  Shared constants and types for the flash write and erase host controller.
  Assumes a 40 MHz system clock and an 8-bit flash with 64 Kbyte blocks.
*/
package fwea_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int BLK_LSB = 16;
  localparam int BLK_W = 4;
  localparam int CNT_W = 6;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYNC_STAGES = 2;
  localparam int T_WE_LOW_NS = 50;
  localparam int T_ACC_NS = 85;
  localparam int T_RDVALID_NS = 400;
  localparam int T_WAKE_NS = 1000;
  localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC =
    (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int RDVALID_CYC =
    (T_RDVALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = 4;
  localparam logic [7:0] CMD_READ_ARRAY = 8'h01;
  localparam logic [7:0] CMD_READ_STATUS = 8'h02;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h03;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h04;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'h05;
  localparam logic [7:0] CMD_SUSPEND = 8'h06;
  localparam logic [7:0] CMD_RESUME = 8'h07;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_STATUS = 3'h1,
    OP_PROGRAM = 3'h2,
    OP_ERASE = 3'h3,
    OP_SUSPEND = 3'h4,
    OP_RESUME = 3'h5,
    OP_POWERDOWN = 3'h6,
    OP_WAKE = 3'h7
  } fwea_op_t;

  typedef struct packed {
    logic valid;
    logic rd;
    logic wait_rdy;
    logic use_data;
    logic [7:0] code;
  } fwea_step_t;
endpackage

// ---- fwea_cyc_if.sv ----
/*
  Carrier for one flash bus cycle between the controller and the pin driver.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface fwea_cyc_if;
  logic req;
  logic wr;
  logic done;
  logic [fwea_pkg::ADDR_W-1:0] addr;
  logic [fwea_pkg::DATA_W-1:0] wdata;
  logic [fwea_pkg::DATA_W-1:0] rdata;
  modport ctrl (output req, output wr, output addr, output wdata,
    input done, input rdata);
  modport seq (input req, input wr, input addr, input wdata,
    output done, output rdata);
endinterface

// ---- fwea_bus_cycle.sv ----
/*
  Flash pin driver that runs one write or read bus cycle per request.
  Assumes the request arrives only while no cycle is running.
*/
`timescale 1ns/10ps
module fwea_bus_cycle (
  input wire logic clock_in,
  input wire logic rst_b_in,
  fwea_cyc_if.seq cyc,
  input wire logic [fwea_pkg::DATA_W-1:0] flash_dq_in,
  output logic [fwea_pkg::ADDR_W-1:0] flash_addr_out,
  output logic [fwea_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_b_out,
  output logic flash_ce_b_out,
  output logic flash_oe_b_out,
  output logic flash_we_b_out
);
  typedef enum logic [4:0] {
    BC_IDLE = 5'h01,
    BC_SETUP = 5'h02,
    BC_STROBE = 5'h04,
    BC_HOLD = 5'h08,
    BC_READ = 5'h10
  } fwea_bc_state_t;

  fwea_bc_state_t state_ff;
  logic [fwea_pkg::CNT_W-1:0] cnt_ff;
  logic [fwea_pkg::DATA_W-1:0] dq_meta_ff;
  logic [fwea_pkg::DATA_W-1:0] dq_sync_ff;

  // Read data is synchronised before it is captured.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dq_meta_ff <= 8'h00;
      dq_sync_ff <= 8'h00;
    end else begin
      dq_meta_ff <= flash_dq_in;
      dq_sync_ff <= dq_meta_ff;
    end
  end

  // Cycle sequencing and its timing counter.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= BC_IDLE;
      cnt_ff <= 6'h00;
    end else begin
      unique case (state_ff)
        BC_IDLE: begin
          if (cyc.req) begin
            state_ff <= cyc.wr ? BC_SETUP : BC_READ;
            cnt_ff <= fwea_pkg::CNT_W'(fwea_pkg::RD_CYC);
          end
        end
        BC_SETUP: begin
          state_ff <= BC_STROBE;
          cnt_ff <= fwea_pkg::CNT_W'(fwea_pkg::WE_LOW_CYC - 1);
        end
        BC_STROBE: begin
          if (cnt_ff == 6'h00) begin
            state_ff <= BC_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        BC_HOLD: state_ff <= BC_IDLE;
        BC_READ: begin
          if (cnt_ff == 6'h00) begin
            state_ff <= BC_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
      endcase
    end
  end

  // Pin levels; address and data stand until after the write strobe rises.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flash_addr_out <= 20'h00000;
      flash_dq_out <= 8'h00;
      flash_dq_oe_b_out <= 1'b1;
      flash_ce_b_out <= 1'b1;
      flash_oe_b_out <= 1'b1;
      flash_we_b_out <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      cyc.done <= 1'b0;
      unique case (state_ff)
        BC_IDLE: begin
          if (cyc.req) begin
            flash_addr_out <= cyc.addr;
            flash_ce_b_out <= 1'b0;
            flash_dq_out <= cyc.wdata;
            flash_dq_oe_b_out <= !cyc.wr;
            flash_oe_b_out <= cyc.wr;
          end
        end
        BC_SETUP: flash_we_b_out <= 1'b0;
        BC_STROBE: begin
          if (cnt_ff == 6'h00) begin
            flash_we_b_out <= 1'b1;
          end
        end
        BC_HOLD: begin
          flash_ce_b_out <= 1'b1;
          flash_dq_oe_b_out <= 1'b1;
          cyc.done <= 1'b1;
        end
        BC_READ: begin
          if (cnt_ff == 6'h00) begin
            cyc.rdata <= dq_sync_ff;
            flash_ce_b_out <= 1'b1;
            flash_oe_b_out <= 1'b1;
            cyc.done <= 1'b1;
          end
        end
      endcase
    end
  end

  a_we_rise_latch: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(flash_we_b_out) |-> !flash_ce_b_out && !flash_dq_oe_b_out
      && $stable(flash_addr_out) ##1 flash_ce_b_out)
    else $error("Write strobe rose without stable address and data.");

  a_idle_standby: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (state_ff == BC_IDLE) && !cyc.req |=> flash_ce_b_out)
    else $error("Chip select held low while no cycle runs.");
endmodule

// ---- fwea_host.sv ----
/*
  Host controller that drives an 8-bit block-erasable flash through its pins.
  Assumes a single clock and a command requester on the same clock.
*/
`timescale 1ns/10ps
// Function
// - Each write or erase is started by two command writes.
// - Erase may be suspended to read other blocks.
// - Wait 400 ns after reset/powerdown rises before reading.
// - Program zero only for bits going from one to zero.
module fwea_host (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_op_in,
  input wire logic [fwea_pkg::ADDR_W-1:0] cmd_addr_in,
  input wire logic [fwea_pkg::DATA_W-1:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic rsp_error_out,
  output logic [fwea_pkg::DATA_W-1:0] rsp_data_out,
  output logic busy_out,
  output logic suspended_out,
  output logic [fwea_pkg::ADDR_W-1:0] flash_addr_out,
  output logic [fwea_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_b_out,
  input wire logic [fwea_pkg::DATA_W-1:0] flash_dq_in,
  output logic flash_ce_b_out,
  output logic flash_oe_b_out,
  output logic flash_we_b_out,
  output logic reset_powerdown_n_out,
  input wire logic ready_busy_n_in
);
  typedef enum logic [6:0] {
    ST_PD = 7'h01,
    ST_WAKE = 7'h02,
    ST_IDLE = 7'h04,
    ST_ISSUE = 7'h08,
    ST_CYC = 7'h10,
    ST_SUSPW = 7'h20,
    ST_RESP = 7'h40
  } fwea_state_t;

  // Bus steps of each operation.
  function automatic fwea_pkg::fwea_step_t fwea_step(
    input fwea_pkg::fwea_op_t op, input logic [2:0] step);
    fwea_pkg::fwea_step_t s;
    s = '0;
    unique case (op)
      fwea_pkg::OP_READ, fwea_pkg::OP_STATUS: begin
        case (step)
          3'h0: s = {4'b1000, (op == fwea_pkg::OP_READ) ?
            fwea_pkg::CMD_READ_ARRAY : fwea_pkg::CMD_READ_STATUS};
          3'h1: s = {4'b1100, 8'h00};
          default: s = '0;
        endcase
      end
      fwea_pkg::OP_PROGRAM: begin
        case (step)
          3'h0: s = {4'b1000, fwea_pkg::CMD_READ_ARRAY};
          3'h1: s = {4'b1100, 8'h00};
          3'h2: s = {4'b1000, fwea_pkg::CMD_PROG_SETUP};
          3'h3: s = {4'b1001, 8'h00};
          default: s = '0;
        endcase
      end
      fwea_pkg::OP_ERASE: begin
        case (step)
          3'h0: s = {4'b1000, fwea_pkg::CMD_ERASE_SETUP};
          3'h1: s = {4'b1000, fwea_pkg::CMD_ERASE_CONFIRM};
          default: s = '0;
        endcase
      end
      fwea_pkg::OP_SUSPEND: begin
        case (step)
          3'h0: s = {4'b1000, fwea_pkg::CMD_SUSPEND};
          3'h1: s = {4'b1010, 8'h00};
          3'h2: s = {4'b1000, fwea_pkg::CMD_READ_STATUS};
          3'h3: s = {4'b1100, 8'h00};
          default: s = '0;
        endcase
      end
      fwea_pkg::OP_RESUME: begin
        case (step)
          3'h0: s = {4'b1000, fwea_pkg::CMD_RESUME};
          default: s = '0;
        endcase
      end
      fwea_pkg::OP_POWERDOWN, fwea_pkg::OP_WAKE: s = '0;
    endcase
    return s;
  endfunction

  // Whether an operation may start in the present engine condition.
  function automatic logic fwea_legal(input fwea_pkg::fwea_op_t op,
    input logic [fwea_pkg::BLK_W-1:0] blk, input logic active,
    input logic susp, input logic erasing, input logic [3:0] ers_blk);
    logic ok;
    ok = 1'b0;
    unique case (op)
      fwea_pkg::OP_READ: ok = !(active && !susp) &&
        !(susp && blk == ers_blk);
      fwea_pkg::OP_STATUS, fwea_pkg::OP_POWERDOWN: ok = 1'b1;
      fwea_pkg::OP_PROGRAM, fwea_pkg::OP_ERASE: ok = !active;
      fwea_pkg::OP_SUSPEND: ok = active && erasing && !susp;
      fwea_pkg::OP_RESUME: ok = susp;
      fwea_pkg::OP_WAKE: ok = 1'b0;
    endcase
    return ok;
  endfunction

  fwea_cyc_if cyc ();
  fwea_state_t state_ff;
  fwea_state_t nxt_state;
  fwea_pkg::fwea_op_t op_ff;
  fwea_pkg::fwea_op_t cmd_op;
  fwea_pkg::fwea_step_t cur;
  logic [2:0] step_ff;
  logic [fwea_pkg::ADDR_W-1:0] addr_ff;
  logic [fwea_pkg::DATA_W-1:0] data_ff;
  logic [fwea_pkg::DATA_W-1:0] old_ff;
  logic cur_rd_ff;
  logic cur_use_ff;
  logic [fwea_pkg::CNT_W-1:0] wake_cnt_ff;
  logic [fwea_pkg::CNT_W-1:0] settle_ff;
  logic [fwea_pkg::BLK_W-1:0] ers_blk_ff;
  logic erasing_ff;
  logic rb_meta_ff;
  logic rb_sync_ff;
  logic take;
  logic refuse;
  logic launch;
  logic [fwea_pkg::CNT_W-1:0] hlp_rp_cnt_ff;

  assign cmd_op = fwea_pkg::fwea_op_t'(cmd_op_in);
  assign take = cmd_valid_in && cmd_ready_out;
  assign cur = fwea_step(op_ff, step_ff);
  assign launch = (state_ff == ST_ISSUE) && !cur.valid &&
    (op_ff == fwea_pkg::OP_PROGRAM || op_ff == fwea_pkg::OP_ERASE);
  assign refuse = take && (((state_ff == ST_PD) && cmd_op !=
    fwea_pkg::OP_WAKE) || ((state_ff == ST_IDLE) && !fwea_legal(cmd_op,
    cmd_addr_in[fwea_pkg::BLK_LSB +: fwea_pkg::BLK_W], busy_out,
    suspended_out, erasing_ff, ers_blk_ff)));

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_PD: if (take && cmd_op == fwea_pkg::OP_WAKE) nxt_state = ST_WAKE;
      ST_WAKE: if (wake_cnt_ff == 6'h00) nxt_state = ST_IDLE;
      ST_IDLE: begin
        if (take && cmd_op == fwea_pkg::OP_POWERDOWN) begin
          nxt_state = ST_PD;
        end else if (take && !refuse) begin
          nxt_state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (!cur.valid) begin
          nxt_state = ST_RESP;
        end else begin
          nxt_state = cur.wait_rdy ? ST_SUSPW : ST_CYC;
        end
      end
      ST_CYC: if (cyc.done) nxt_state = ST_ISSUE;
      ST_SUSPW: if (rb_sync_ff) nxt_state = ST_ISSUE;
      ST_RESP: nxt_state = ST_IDLE;
    endcase
  end

  // Ready/busy from the device is synchronised before use.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rb_meta_ff <= 1'b0;
      rb_sync_ff <= 1'b0;
    end else begin
      rb_meta_ff <= ready_busy_n_in;
      rb_sync_ff <= rb_meta_ff;
    end
  end

  // Sequencer state, step pointer and captured request.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_WAKE;
      step_ff <= 3'h0;
      op_ff <= fwea_pkg::OP_READ;
      addr_ff <= 20'h00000;
      data_ff <= 8'h00;
      cmd_ready_out <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ready_out <= (nxt_state == ST_IDLE) || (nxt_state == ST_PD);
      if (state_ff == ST_IDLE && nxt_state == ST_ISSUE) begin
        op_ff <= cmd_op;
        addr_ff <= cmd_addr_in;
        data_ff <= cmd_data_in;
        step_ff <= 3'h0;
      end else if ((state_ff == ST_CYC && cyc.done) ||
        (state_ff == ST_SUSPW && rb_sync_ff)) begin
        step_ff <= step_ff + 3'h1;
      end
    end
  end

  // Bus cycle requests to the pin driver.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cyc.req <= 1'b0;
      cyc.wr <= 1'b0;
      cyc.addr <= 20'h00000;
      cyc.wdata <= 8'h00;
      cur_rd_ff <= 1'b0;
      cur_use_ff <= 1'b0;
      old_ff <= 8'h00;
    end else begin
      cyc.req <= (state_ff == ST_ISSUE) && cur.valid && !cur.wait_rdy;
      if (state_ff == ST_ISSUE) begin
        cyc.wr <= !cur.rd;
        cyc.addr <= addr_ff;
        cyc.wdata <= cur.use_data ? (data_ff | ~old_ff) : cur.code;
        cur_rd_ff <= cur.rd;
        cur_use_ff <= cur.use_data;
      end
      if (state_ff == ST_CYC && cyc.done && cur_rd_ff) begin
        old_ff <= cyc.rdata;
      end
    end
  end

  // Responses to the requester.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsp_valid_out <= 1'b0;
      rsp_error_out <= 1'b0;
      rsp_data_out <= 8'h00;
    end else begin
      rsp_valid_out <= (state_ff == ST_RESP) || refuse ||
        (take && !refuse && (cmd_op == fwea_pkg::OP_POWERDOWN ||
        cmd_op == fwea_pkg::OP_WAKE));
      rsp_error_out <= refuse;
      if (state_ff == ST_CYC && cyc.done && cur_rd_ff) begin
        rsp_data_out <= cyc.rdata;
      end
    end
  end

  // Power control and wake timing.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reset_powerdown_n_out <= 1'b0;
      wake_cnt_ff <= fwea_pkg::CNT_W'(fwea_pkg::WAKE_CYC);
    end else begin
      reset_powerdown_n_out <= (nxt_state != ST_PD);
      if (state_ff == ST_PD) begin
        wake_cnt_ff <= fwea_pkg::CNT_W'(fwea_pkg::WAKE_CYC);
      end else if (reset_powerdown_n_out && wake_cnt_ff != 6'h00) begin
        wake_cnt_ff <= wake_cnt_ff - 6'h01;
      end
    end
  end

  // Engine activity as seen from the host.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
      suspended_out <= 1'b0;
      erasing_ff <= 1'b0;
      ers_blk_ff <= 4'h0;
      settle_ff <= 6'h00;
    end else if (!reset_powerdown_n_out) begin
      busy_out <= 1'b0;
      suspended_out <= 1'b0;
      erasing_ff <= 1'b0;
      settle_ff <= 6'h00;
    end else if (launch) begin
      busy_out <= 1'b1;
      erasing_ff <= (op_ff == fwea_pkg::OP_ERASE);
      ers_blk_ff <= addr_ff[fwea_pkg::BLK_LSB +: fwea_pkg::BLK_W];
      settle_ff <= fwea_pkg::CNT_W'(fwea_pkg::SETTLE_CYC);
    end else if (state_ff == ST_ISSUE && !cur.valid &&
      op_ff == fwea_pkg::OP_SUSPEND) begin
      suspended_out <= 1'b1;
    end else if (state_ff == ST_ISSUE && !cur.valid &&
      op_ff == fwea_pkg::OP_RESUME) begin
      suspended_out <= 1'b0;
      settle_ff <= fwea_pkg::CNT_W'(fwea_pkg::SETTLE_CYC);
    end else if (settle_ff != 6'h00) begin
      settle_ff <= settle_ff - 6'h01;
    end else if (busy_out && !suspended_out && rb_sync_ff &&
      op_ff != fwea_pkg::OP_SUSPEND) begin
      busy_out <= 1'b0;
    end
  end

  // Cycles since reset/powerdown last rose, saturating.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hlp_rp_cnt_ff <= 6'h00;
    end else if (!reset_powerdown_n_out) begin
      hlp_rp_cnt_ff <= 6'h00;
    end else if (hlp_rp_cnt_ff != 6'h3F) begin
      hlp_rp_cnt_ff <= hlp_rp_cnt_ff + 6'h01;
    end
  end

  fwea_bus_cycle u_bus_cycle (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .cyc(cyc.seq),
    .flash_dq_in(flash_dq_in),
    .flash_addr_out(flash_addr_out),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_b_out(flash_dq_oe_b_out),
    .flash_ce_b_out(flash_ce_b_out),
    .flash_oe_b_out(flash_oe_b_out),
    .flash_we_b_out(flash_we_b_out)
  );

  a_wake_cmd_gap: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    !flash_we_b_out |-> hlp_rp_cnt_ff >= 6'h28)
    else $error("Command written before the wake time elapsed.");
  a_wake_read_gap: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    !flash_oe_b_out |-> hlp_rp_cnt_ff >= 6'h10)
    else $error("Read started before outputs were valid.");
  a_pd_no_access: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    !reset_powerdown_n_out |-> flash_we_b_out && flash_oe_b_out)
    else $error("Bus access during deep powerdown.");
  a_pd_clears: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    !reset_powerdown_n_out |=> !busy_out && !suspended_out)
    else $error("Engine state survived powerdown.");
  a_busy_refuse: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    take && busy_out && (cmd_op == fwea_pkg::OP_PROGRAM ||
      cmd_op == fwea_pkg::OP_ERASE) |=> rsp_valid_out && rsp_error_out)
    else $error("Write or erase accepted while engine busy.");
  a_erase_two_writes: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(busy_out) |-> $past(cyc.done, 2) && erasing_ff == (op_ff ==
      fwea_pkg::OP_ERASE) ##1 busy_out[*4])
    else $error("Engine marked busy without a completed command pair.");
  a_susp_other_blk: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    cyc.req && suspended_out && !cyc.wr |->
      cyc.addr[fwea_pkg::BLK_LSB +: fwea_pkg::BLK_W] != ers_blk_ff)
    else $error("Read from the block under suspended erase.");
  a_prog_mask: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    cyc.req && cur_use_ff |-> (~cyc.wdata & ~old_ff) == 8'h00)
    else $error("Programmed zero onto a bit already zero.");
  a_busy_release: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    busy_out && !suspended_out && settle_ff == 6'h00 && rb_sync_ff &&
      reset_powerdown_n_out && !launch && op_ff != fwea_pkg::OP_SUSPEND
      |=> !busy_out)
    else $error("Busy held after the engine reported ready.");
endmodule

// ---- fwea_flash_model.sv ----
/*
  Behavioural model of the block-erasable flash seen by the host.
  Assumes the bench resolves the data pins and feeds the value here.
*/
`timescale 1ns/10ps
module fwea_flash_model #(
  parameter int PROG_NS = 500,
  parameter int ERASE_NS = 4000
) (
  input wire logic [19:0] addr_in,
  input wire logic [7:0] dq_in,
  input wire logic ce_b_in,
  input wire logic oe_b_in,
  input wire logic we_b_in,
  input wire logic rp_n_in,
  output logic [7:0] dq_out,
  output logic ready_busy_n_out
);
  logic [7:0] mem [int];
  logic [7:0] last_prog = 8'h00;
  logic [19:0] op_addr = 20'h00000;
  logic [19:0] ea;
  logic [7:0] op_data = 8'h00;
  logic [7:0] ed;
  logic st_mode = 1'b0;
  logic erasing = 1'b0;
  logic ek;
  logic busy = 1'b0;
  logic susp = 1'b0;
  logic [1:0] pend = 2'h0;
  realtime t_rise = 0.0;
  event start;
  int left;
  int q[$];
  initial dq_out = 8'h00;
  function automatic logic [7:0] rd(input logic [19:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction
  assign ready_busy_n_out = !busy || susp || !rp_n_in;
  always @(negedge rp_n_in) begin
    busy = 1'b0;
    susp = 1'b0;
    pend = 2'h0;
    st_mode = 1'b0;
  end
  always @(posedge rp_n_in) t_rise = $realtime;
  always @(posedge we_b_in) begin
    if (!ce_b_in && rp_n_in && $realtime - t_rise >= 1000.0) begin
      op_addr = addr_in;
      op_data = dq_in;
      if (pend != 2'h0) begin
        erasing = pend[1];
        st_mode = 1'b1;
        if (pend == 2'h1) begin
          last_prog = dq_in;
        end
        if (pend == 2'h1 || dq_in == fwea_pkg::CMD_ERASE_CONFIRM) begin
          ->start;
        end
        pend = 2'h0;
      end else begin
        case (dq_in)
          fwea_pkg::CMD_READ_ARRAY: st_mode = 1'b0;
          fwea_pkg::CMD_READ_STATUS: st_mode = 1'b1;
          fwea_pkg::CMD_PROG_SETUP: pend = 2'h1;
          fwea_pkg::CMD_ERASE_SETUP: pend = 2'h2;
          fwea_pkg::CMD_SUSPEND: susp = busy && erasing;
          fwea_pkg::CMD_RESUME: susp = 1'b0;
          default: st_mode = st_mode;
        endcase
      end
    end
  end
  always @(start) begin
    ek = erasing;
    ea = op_addr;
    ed = op_data;
    busy = 1'b1;
    left = ek ? ERASE_NS : PROG_NS;
    while (left > 0 && busy) begin
      #100;
      left = susp ? left : left - 100;
    end
    if (busy && ek) begin
      q.delete();
      foreach (mem[k]) if ((k >> 16) == int'(ea[19:16])) q.push_back(k);
      foreach (q[i]) mem.delete(q[i]);
    end else if (busy) begin
      mem[int'(ea)] = rd(ea) & ed;
    end
    busy = 1'b0;
  end
  always begin
    #5;
    if (!ce_b_in && !oe_b_in && rp_n_in && $realtime - t_rise >= 400.0) begin
      dq_out = st_mode ? {ready_busy_n_out, susp, 6'h00} : rd(addr_in);
    end else begin
      dq_out = ~dq_out;
    end
  end
endmodule

// ---- tb_top.sv ----
/*
  Self-checking bench for the flash host controller.
  Assumes the flash model stands on the far side of the pins.
*/
`timescale 1ns/10ps
module tb_top;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cv = 1'b0;
  logic [2:0] cop = 3'h0;
  logic [19:0] cad = 20'h00000;
  logic [7:0] cdt = 8'h00;
  logic rdy, rv, re, busy, susp, dq_oe_b, ce_b, oe_b, we_b, rp_n, rb_n;
  logic [7:0] rd_b, host_dq, dev_dq, dq_w, dat_s;
  logic [19:0] fa;
  logic err_s;
  int n_mismatch = 0;
  int n_checks = 0;
  assign dq_w = !dq_oe_b ? host_dq : dev_dq;
  always #12.5 clock_in = ~clock_in;
  fwea_host i_fwea_host (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .cmd_valid_in(cv), .cmd_op_in(cop), .cmd_addr_in(cad),
    .cmd_data_in(cdt), .cmd_ready_out(rdy), .rsp_valid_out(rv),
    .rsp_error_out(re), .rsp_data_out(rd_b), .busy_out(busy),
    .suspended_out(susp), .flash_addr_out(fa), .flash_dq_out(host_dq),
    .flash_dq_oe_b_out(dq_oe_b), .flash_dq_in(dq_w),
    .flash_ce_b_out(ce_b), .flash_oe_b_out(oe_b), .flash_we_b_out(we_b),
    .reset_powerdown_n_out(rp_n), .ready_busy_n_in(rb_n));
  fwea_flash_model i_fwea_flash_model (.addr_in(fa), .dq_in(dq_w),
    .ce_b_in(ce_b), .oe_b_in(oe_b), .we_b_in(we_b), .rp_n_in(rp_n),
    .dq_out(dev_dq), .ready_busy_n_out(rb_n));
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [2:0] op, input logic [19:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    cv <= 1'b1;
    cop <= op;
    cad <= a;
    cdt <= d;
    do @(negedge clock_in); while (rdy !== 1'b1 && n++ < 500);
    if (n > 500) n_mismatch++;
    @(posedge clock_in);
    cv <= 1'b0;
    do @(negedge clock_in); while (rv !== 1'b1 && n++ < 5000);
    if (n > 5000) n_mismatch++;
    err_s = re;
    dat_s = rd_b;
  endtask
  task automatic idle();
    int n;
    n = 0;
    do @(negedge clock_in); while (busy !== 1'b0 && n++ < 5000);
    if (n > 5000) n_mismatch++;
  endtask
  task automatic t_prog();
    cmd(3'h0, 20'h00010, 8'h00);
    chk("boot read", 8'hFF, dat_s);
    cmd(3'h2, 20'h12345, 8'h5A);
    chk("old byte", 8'hFF, dat_s);
    chk("busy", 8'h01, {7'h00, busy});
    cmd(3'h2, 20'h12345, 8'h00);
    chk("refused", 8'h01, {7'h00, err_s});
    idle();
    cmd(3'h2, 20'h12345, 8'h50);
    chk("prog byte", 8'hF5, i_fwea_flash_model.last_prog);
    idle();
    cmd(3'h0, 20'h12345, 8'h00);
    chk("read back", 8'h50, dat_s);
    cmd(3'h2, 20'hFFFFF, 8'hA5);
    idle();
    cmd(3'h0, 20'hFFFFF, 8'h00);
    chk("top byte", 8'hA5, dat_s);
    cmd(3'h2, 20'h20000, 8'h33);
    idle();
    $display("program test done");
  endtask
  task automatic t_erase();
    cmd(3'h3, 20'h10000, 8'h00);
    chk("erase ok", 8'h00, {7'h00, err_s});
    cmd(3'h4, 20'h00000, 8'h00);
    chk("suspended", 8'h01, {7'h00, susp});
    chk("ready susp", 8'h01, {7'h00, rb_n});
    cmd(3'h0, 20'h10000, 8'h00);
    chk("same block", 8'h01, {7'h00, err_s});
    cmd(3'h0, 20'h20000, 8'h00);
    chk("other block", 8'h33, dat_s);
    cmd(3'h5, 20'h00000, 8'h00);
    idle();
    cmd(3'h0, 20'h12345, 8'h00);
    chk("erased", 8'hFF, dat_s);
    cmd(3'h0, 20'h20000, 8'h00);
    chk("kept", 8'h33, dat_s);
    cmd(3'h1, 20'h00000, 8'h00);
    chk("status", 8'h80, dat_s);
    $display("erase test done");
  endtask
  task automatic t_pd();
    cmd(3'h6, 20'h00000, 8'h00);
    chk("powerdown", 8'h00, {7'h00, rp_n});
    chk("ready pd", 8'h01, {7'h00, rb_n});
    cmd(3'h0, 20'h20000, 8'h00);
    chk("pd refuse", 8'h01, {7'h00, err_s});
    cmd(3'h7, 20'h00000, 8'h00);
    cmd(3'h0, 20'h20000, 8'h00);
    chk("wake read", 8'h33, dat_s);
    $display("powerdown test done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    t_prog();
    t_erase();
    t_pd();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    n_mismatch++;
    summarize();
  end
endmodule
